// *** core/pser_pkg.sv ***
// shared constants for the 7:1 pixel serializer
package pser_pkg;
  localparam int unsigned NUM_LANES   = 4;
  localparam int unsigned SLICE_W     = 7;
  localparam int unsigned DATA_W      = NUM_LANES * SLICE_W;
  localparam int unsigned PER_W       = 10;
  localparam int unsigned BIT_MULT    = 7;
  localparam int unsigned REF_CLK_MHZ = 200;
  localparam int unsigned PIX_MIN_MHZ = 10;
  localparam int unsigned PIX_MAX_MHZ = 85;
  // longest legal pixel period in reference cycles
  localparam int unsigned PIX_PER_MAX_CYC = REF_CLK_MHZ / PIX_MIN_MHZ;
  localparam logic [PER_W-1:0] MULT_STEP   = 10'h007;
  localparam logic [2:0]       BITS_AFTER_LOAD = 3'h6;
  // forwarded clock slice, sent first bit at the msb: high-high-low-low-low-high-high
  localparam logic [SLICE_W-1:0] CLK_PATTERN = 7'h63;
  localparam logic [PER_W-1:0] PER_RESET = 10'h000;
endpackage

// *** core/pser_shift_if.sv ***
// carrier between sequencer and the lane shift registers
interface pser_shift_if;
  import pser_pkg::*;
  logic                 load;
  logic                 shift;
  logic                 clear;
  logic [DATA_W-1:0]    data;
  logic [NUM_LANES-1:0] serial;
  logic                 clk_bit;
  modport ctrl    (output load, output shift, output clear, output data,
                   input serial, input clk_bit);
  modport shifter (input load, input shift, input clear, input data,
                   output serial, output clk_bit);
endinterface

// *** core/pser_shifter.sv ***
// four parallel-load serial-out lane registers plus the clock pattern register
module pser_shifter
  import pser_pkg::*;
(
  input  wire logic   ref_clk_in,
  input  wire logic   rst_in,
  pser_shift_if.shifter sh
);

  typedef struct packed {
    logic [NUM_LANES-1:0][SLICE_W-1:0] lane;
    logic [SLICE_W-1:0]                clk;
  } pser_sh_s;

  pser_sh_s st_reg;
  pser_sh_s st_next;

  // ==========================================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    if (sh.clear)
    begin
      st_next = '0;
    end
    else if (sh.load)
    begin
      for (int k = 0; k < NUM_LANES; k++)
      begin
        st_next.lane[k] = sh.data[k*SLICE_W +: SLICE_W];
      end
      st_next.clk = CLK_PATTERN;
    end
    else if (sh.shift)
    begin
      for (int k = 0; k < NUM_LANES; k++)
      begin
        st_next.lane[k] = {st_reg.lane[k][SLICE_W-2:0], 1'b0};
      end
      st_next.clk = {st_reg.clk[SLICE_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  always_comb
  begin
    for (int k = 0; k < NUM_LANES; k++)
    begin
      sh.serial[k] = st_reg.lane[k][SLICE_W-1];
    end
  end
  assign sh.clk_bit = st_reg.clk[SLICE_W-1];

  // ==========================================================
  // checks
  a_clear_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    sh.clear |=> (st_reg == '0))
    else $error("shifter not cleared by shutdown");
  a_load_map: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (sh.load && !sh.clear) |=> (st_reg.lane == $past(sh.data)))
    else $error("lane registers do not hold captured word");
  a_shift_move: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (sh.shift && !sh.load && !sh.clear) |=>
      (st_reg.lane[0] == {$past(st_reg.lane[0][SLICE_W-2:0]), 1'b0}))
    else $error("lane did not advance by one bit");
  a_clk_pattern: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (sh.load && !sh.clear) |=> (st_reg.clk == CLK_PATTERN))
    else $error("clock pattern not reloaded per pixel period");

endmodule

// *** core/pser_top.sv ***
// pixel serializer: captures 28 bits per pixel clock and sends four 7:1 lanes
module pser_top
  import pser_pkg::*;
//
// Contract
// - capture all 28 inputs on selected edge
// - bit strobe at seven times pixel rate
// - four 7-bit shifters, one slice per period
// - four data lanes plus clock out
// - forwarded clock equals pixel clock frequency
// - shutdown stops clocking, disables drivers
// - shutdown clears all registers but the synchronisers and clk_prev to zero
// - receiver recovers the same 28-bit word
// - outputs undriven while shutdown low
#(
  parameter int unsigned PERIOD_W = PER_W
)
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 pixel_clock_in,
  input  wire logic                 capture_edge_select_in,
  input  wire logic                 shutdown_clear_n_in,
  input  wire logic [DATA_W-1:0]    pixel_data_in,
  output logic      [NUM_LANES-1:0] lane_pos_out,
  output logic      [NUM_LANES-1:0] lane_neg_out,
  output logic      [NUM_LANES-1:0] lane_oe_out,
  output logic                      link_clock_pos_out,
  output logic                      link_clock_neg_out,
  output logic                      link_clock_oe_out
);

  typedef struct packed {
    logic                 clk_s1;
    logic                 clk_s2;
    logic                 sel_s1;
    logic                 sel_s2;
    logic                 run_s1;
    logic                 run_s2;
    logic [DATA_W-1:0]    dat_s1;
    logic [DATA_W-1:0]    dat_s2;
    logic                 clk_prev;
    logic [PERIOD_W-1:0]  cnt;
    logic [PERIOD_W-1:0]  period;
    logic [PERIOD_W-1:0]  acc;
    logic [2:0]           bits_left;
    logic                 primed;
    logic [NUM_LANES-1:0] lane_p;
    logic [NUM_LANES-1:0] lane_n;
    logic [NUM_LANES-1:0] lane_oe;
    logic                 lclk_p;
    logic                 lclk_n;
    logic                 lclk_oe;
  } pser_top_s;

  pser_top_s st_reg;
  pser_top_s st_next;

  pser_shift_if sh ();

  logic                run;
  logic                edge_hit;
  logic [PERIOD_W-1:0] acc_step;

  assign run      = st_reg.run_s2;
  assign acc_step = st_reg.acc + PERIOD_W'(MULT_STEP);

  // edges are found on the synchronised copy; the raw pin feeds only the first flop
  always_comb
  begin
    if (st_reg.sel_s2)
      edge_hit = st_reg.clk_s2 & ~st_reg.clk_prev;
    else
      edge_hit = ~st_reg.clk_s2 & st_reg.clk_prev;
  end

  // ==========================================================
  // sequencer
  // limitation: seven strobes need a pixel period of at least seven
  // reference cycles, so the fastest pixel rates need a faster reference
  always_comb
  begin
    st_next        = st_reg;
    sh.load        = 1'b0;
    sh.shift       = 1'b0;
    sh.clear       = ~run;
    sh.data        = st_reg.dat_s2;
    // pins pass two flops before use
    st_next.clk_s1 = pixel_clock_in;
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.sel_s1 = capture_edge_select_in;
    st_next.sel_s2 = st_reg.sel_s1;
    st_next.run_s1 = shutdown_clear_n_in;
    st_next.run_s2 = st_reg.run_s1;
    st_next.dat_s1 = pixel_data_in;
    st_next.dat_s2 = st_reg.dat_s1;
    st_next.clk_prev = st_reg.clk_s2;
    if (!run)
    begin
      // everything but the synchronisers and clk_prev drops to zero, drivers released
      st_next.cnt       = '0;
      st_next.period    = PERIOD_W'(PER_RESET);
      st_next.acc       = '0;
      st_next.bits_left = '0;
      st_next.primed    = 1'b0;
      st_next.lane_p    = '0;
      st_next.lane_n    = '0;
      st_next.lane_oe   = '0;
      st_next.lclk_p    = 1'b0;
      st_next.lclk_n    = 1'b0;
      st_next.lclk_oe   = 1'b0;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
      if (edge_hit)
      begin
        // synchronised data and clock share latency, so the word is coherent
        sh.load           = 1'b1;
        // the count since start-up is not a period: the first slice after
        // reset or shutdown runs unpaced and the next edge measures
        if (st_reg.primed)
        begin
          st_next.period  = st_reg.cnt + 1'b1;
        end
        st_next.primed    = 1'b1;
        st_next.cnt       = '0;
        st_next.acc       = '0;
        st_next.bits_left = BITS_AFTER_LOAD;
      end
      else if (st_reg.bits_left != 3'h0)
      begin
        // seven strobes spread evenly over the last measured period;
        // a shorter next period truncates the slice rather than slipping
        if (acc_step >= st_reg.period)
        begin
          sh.shift          = 1'b1;
          st_next.acc       = acc_step - st_reg.period;
          st_next.bits_left = st_reg.bits_left - 1'b1;
        end
        else
        begin
          st_next.acc = acc_step;
        end
      end
      st_next.lane_p  = sh.serial;
      st_next.lane_n  = ~sh.serial;
      st_next.lane_oe = '1;
      st_next.lclk_p  = sh.clk_bit;
      st_next.lclk_n  = ~sh.clk_bit;
      st_next.lclk_oe = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  pser_shifter u_shifter (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .sh         (sh.shifter)
  );

  assign lane_pos_out       = st_reg.lane_p;
  assign lane_neg_out       = st_reg.lane_n;
  assign lane_oe_out        = st_reg.lane_oe;
  assign link_clock_pos_out = st_reg.lclk_p;
  assign link_clock_neg_out = st_reg.lclk_n;
  assign link_clock_oe_out  = st_reg.lclk_oe;

  // ==========================================================
  // checks
  a_capture_word: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (run && edge_hit) |-> (sh.load && sh.data == st_reg.dat_s2))
    else $error("selected edge did not load the word");
  a_bit_budget: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    sh.shift |-> (st_reg.bits_left != 3'h0 && !edge_hit))
    else $error("more than seven bits per period");
  a_dda_bound: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (run && st_reg.period != '0) |-> (st_reg.acc < st_reg.period))
    else $error("bit strobe accumulator out of range");
  a_drivers_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !run |=> (lane_oe_out == '0 && !link_clock_oe_out && lane_pos_out == '0))
    else $error("drivers enabled during shutdown");
  a_lane_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    run |=> (lane_pos_out == $past(sh.serial) && lane_neg_out == ~lane_pos_out
             && link_clock_pos_out == $past(sh.clk_bit)))
    else $error("lane outputs do not follow shifters");
  a_stop_clock: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!run ##1 !run) |-> (!sh.load && !sh.shift && st_reg.bits_left == 3'h0))
    else $error("internal clocking active in shutdown");
  a_shut_state: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!run ##1 !run) |-> (st_reg.cnt == '0 && st_reg.acc == '0
                         && st_reg.period == '0 && !st_reg.primed))
    else $error("sequencer state not cleared by shutdown");
  a_pins_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !run |=> (lane_neg_out == '0 && !link_clock_neg_out && !link_clock_pos_out))
    else $error("output pins not idle during shutdown");
  a_oe_on: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    run |=> (lane_oe_out == '1 && link_clock_oe_out))
    else $error("drivers not enabled while running");
  a_cnt_step: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (run && !edge_hit) |=> (st_reg.cnt == $past(st_reg.cnt) + 1'b1))
    else $error("period counter skipped a reference cycle");
  a_period_meas: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (run && edge_hit && st_reg.primed) |=>
      (st_reg.period == $past(st_reg.cnt) + 1'b1))
    else $error("pixel period not measured between selected edges");
  // pacing check assumes periods of seven reference cycles or more
  a_slice_done: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (run && edge_hit && st_reg.primed && st_reg.period != '0
     && st_reg.cnt + 1'b1 == st_reg.period) |-> (st_reg.bits_left == 3'h0))
    else $error("slice not fully sent within a steady pixel period");

endmodule

// *** dv/pser_rx_model.sv ***
// receiver model: rebuilds pixel words from the four serial lanes
module pser_rx_model
  import pser_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic [NUM_LANES-1:0] lane_in,
  input  wire logic [NUM_LANES-1:0] lane_oe_in,
  input  wire logic                 link_clk_in,
  output logic      [DATA_W-1:0]    word_out,
  output logic                      word_ok_out,
  output int                        per_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // mid-bit sampling
  logic [DATA_W-1:0]    acc = '0;
  logic [NUM_LANES-1:0] q = '0;
  logic                 lc = 1'b0;
  int                   c = 0;
  int                   n = 7;
  int                   per = 0;
  int                   p;
  initial
    word_ok_out = 1'b0;
  // a released lane reads back as a level that flips every cycle
  always @(posedge ref_clk_in)
  begin
    q = (lane_in & lane_oe_in) | (~q & ~lane_oe_in);
    c++;
    word_ok_out <= 1'b0;
    if (link_clk_in && !lc)
    begin
      per = c;
      c = 0;
      n = 0;
    end
    lc = link_clk_in;
    // link clock rises at slice position 5, msb of each slice first
    if (n < 7 && c == ((2 * n + 1) * per) / 14)
    begin
      p = (n + 5) % 7;
      for (int k = 0; k < NUM_LANES; k++)
        acc[7 * k + 6 - p] = q[k];
      if (p == 6)
      begin
        word_out    <= acc;
        word_ok_out <= 1'b1;
      end
      n++;
    end
    per_out <= per;
  end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the pixel serializer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pser_pkg::*;
  // ====================
  // signals and instances
  localparam logic [DATA_W-1:0] ALL    = 28'hFFFFFFF;
  localparam logic [DATA_W-1:0] MASK18 = 28'h77CF3DF;
  logic                 ref_clk, rst, pix_clk, sel, run_n, cp, cn, coe, rx_ok;
  logic [DATA_W-1:0]    pix_data, mask, rx_word;
  logic [NUM_LANES-1:0] lp, ln, loe;
  int                   rx_per, idx;
  int                   num_errors = 0;
  int                   comparisons = 0;
  logic [DATA_W-1:0]    sent[$];

  pser_top u_dut (.ref_clk_in(ref_clk), .rst_in(rst), .pixel_clock_in(pix_clk),
    .capture_edge_select_in(sel), .shutdown_clear_n_in(run_n), .pixel_data_in(pix_data),
    .lane_pos_out(lp), .lane_neg_out(ln), .lane_oe_out(loe), .link_clock_pos_out(cp),
    .link_clock_neg_out(cn), .link_clock_oe_out(coe));
  pser_rx_model u_rx (.ref_clk_in(ref_clk), .lane_in(lp), .lane_oe_in(loe),
    .link_clk_in(cp), .word_out(rx_word), .word_ok_out(rx_ok), .per_out(rx_per));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // free running, phase unrelated to ref_clk
  initial
  begin
    pix_clk = 1'b0;
    #1.3;
    forever #80 pix_clk = ~pix_clk;
  end
  // data moves on the unselected edge so it is stable at capture
  always @(pix_clk)
    if (pix_clk === sel)
      sent.push_back(pix_data);
    else
      pix_data <= (pix_data + 28'h1D4C3B7) & mask;

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic get_word;
    int t;
    t = 0;
    do
    begin
      @(posedge ref_clk);
      t++;
    end while (rx_ok !== 1'b1 && t < 100);
    if (t >= 100)
      check(rx_ok, 1'b1);
  endtask

  task automatic t_stream(input logic s, input logic [DATA_W-1:0] m);
    bit hit;
    @(posedge ref_clk);
    sel  <= s;
    mask <= m;
    repeat (128) @(posedge ref_clk);
    sent.delete();
    repeat (96) @(posedge ref_clk);
    get_word();
    hit = 0;
    foreach (sent[i])
      if (sent[i] === rx_word && !hit)
      begin
        hit = 1;
        idx = i + 1;
      end
    check(hit, 1'b1);
    repeat (6)
    begin
      get_word();
      check(rx_word, sent[idx]);
      check(rx_word & ~m, 28'h0);
      check(28'(rx_per), 28'h20);
      check({ln, cn, loe, coe}, {~lp, ~cp, 5'h1F});
      idx++;
    end
    $display("stream done sel=%0b", s);
  endtask

  task automatic t_shutdown;
    int toggles;
    @(posedge ref_clk);
    run_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({loe, coe, lp, cp, ln, cn}, 28'h0);
    toggles = 0;
    repeat (96)
    begin
      @(posedge ref_clk);
      toggles += (cp !== 1'b0 || coe !== 1'b0);
    end
    check(28'(toggles), 28'h0);
    run_n <= 1'b1;
    $display("shutdown done");
  endtask

  // ====================
  // main sequence
  initial
  begin
    rst = 1'b1;
    sel = 1'b1;
    run_n = 1'b1;
    pix_data = '0;
    mask = ALL;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_stream(1'b1, ALL);
    t_stream(1'b0, ALL);
    t_stream(1'b1, MASK18);
    t_shutdown();
    t_stream(1'b0, ALL);
    close_out();
  end
  // the tests need about 9 us
  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule
